// ### core/config_prom_readout.sv
// Sequential read-out core of a cascadable configuration memory
`timescale 1ns/1ns
module config_prom_readout #(
    parameter int unsigned HOLD_CYCLES = cfg_prom_pkg::HOLD_CYCLES
)(
    input  wire logic                            clk,
    input  wire logic                            sys_rst,
    input  wire logic                            configClock,
    input  wire logic                            chipEnableN,
    input  wire logic                            oeResetInN,
    input  wire logic                            parallelMode,
    input  wire logic                            supplyLow,
    input  wire logic                            progWe,
    input  wire logic [cfg_prom_pkg::ADDR_W-1:0] progAddr,
    input  wire logic [7:0]                      progData,
    output logic                                 serialDataOut,
    output logic                                 serialDataOe,
    output logic [6:0]                           parallelDataOut,
    output logic                                 parallelDataOe,
    output logic                                 cascadeEnableOutN,
    output logic                                 oeResetOutN,
    output logic                                 oeResetOe
);
    rst_hold_if hif ();

    reset_hold #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .clk     (clk),
        .sys_rst (sys_rst),
        .hif     (hif)
    );

    assign hif.brownOut = supplyLow;

    logic [7:0] mem [cfg_prom_pkg::MEM_DEPTH];

    cfg_prom_pkg::readout_state_type stateQ;
    cfg_prom_pkg::readout_state_type stateD;
    logic [cfg_prom_pkg::ADDR_W-1:0] addrQ;
    logic [cfg_prom_pkg::ADDR_W-1:0] addrD;
    logic [2:0]                      bitQ;
    logic [2:0]                      bitD;
    logic                            modeQ;
    logic                            modeD;
    logic                            ccPrevQ;
    logic                            ccPrevD;
    logic                            serialD;
    logic                            serialOeD;
    logic [6:0]                      upperD;
    logic                            upperOeD;
    logic                            cascadeD;
    logic                            lineLowD;
    logic                            lineOeD;
    logic                            clearing;
    logic                            rise;
    logic [7:0]                      word;

    // End of a byte: every rising clock edge in parallel mode, the eighth bit in serial mode
    function automatic logic byteEnd(input logic par, input logic [2:0] bitPos);
        byteEnd = par || (bitPos == cfg_prom_pkg::BIT_LAST);
    endfunction

    // Serial order is most significant bit first
    function automatic logic pickBit(input logic [7:0] w, input logic [2:0] bitPos);
        pickBit = w[cfg_prom_pkg::BIT_LAST - bitPos];
    endfunction

    // Loader port only; a write during a read-out is not guarded against
    always_ff @(posedge clk)
    begin
        if (progWe)
        begin
            mem[progAddr] <= progData;
        end
    end

    always_comb
    begin
        // Pin level, own hold or standby; own hold also pulls the shared line low
        clearing = !oeResetInN || hif.holdActive || chipEnableN;
        rise     = configClock && !ccPrevQ;
        stateD   = stateQ;
        addrD    = addrQ;
        bitD     = bitQ;
        modeD    = modeQ;
        if (clearing)
        begin
            stateD = cfg_prom_pkg::ST_HELD;
            addrD  = cfg_prom_pkg::ADDR_RESET;
            bitD   = cfg_prom_pkg::BIT_FIRST;
            // Mode only latched while held so a stream never switches width
            modeD  = parallelMode;
        end
        else
        begin
            case (stateQ)
                cfg_prom_pkg::ST_HELD:
                begin
                    stateD = cfg_prom_pkg::ST_SEND;
                end
                cfg_prom_pkg::ST_SEND:
                begin
                    if (rise)
                    begin
                        if (byteEnd(modeQ, bitQ))
                        begin
                            if (addrQ == cfg_prom_pkg::TERMINAL_COUNT)
                            begin
                                stateD = cfg_prom_pkg::ST_DONE;
                            end
                            else
                            begin
                                addrD = addrQ + 1'b1;
                                bitD  = cfg_prom_pkg::BIT_FIRST;
                            end
                        end
                        else
                        begin
                            bitD = bitQ + 1'b1;
                        end
                    end
                end
                cfg_prom_pkg::ST_DONE:
                begin
                    stateD = cfg_prom_pkg::ST_DONE;
                end
                default:
                begin
                    stateD = cfg_prom_pkg::ST_HELD;
                end
            endcase
        end
        ccPrevD = configClock;
    end

    // Pins follow the next counter values so data and counters move together
    always_comb
    begin
        word      = mem[addrD];
        serialOeD = (stateD == cfg_prom_pkg::ST_SEND);
        serialD   = modeD ? word[0] : pickBit(word, bitD);
        upperD    = word[7:1];
        upperOeD  = serialOeD && modeD;
        cascadeD  = (stateD != cfg_prom_pkg::ST_DONE);
    end

    // Open-drain style line: level always low, only the enable moves
    always_comb
    begin
        lineLowD = 1'h0;
        lineOeD  = hif.holdActive;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stateQ  <= cfg_prom_pkg::ST_HELD;
            addrQ   <= cfg_prom_pkg::ADDR_RESET;
            bitQ    <= cfg_prom_pkg::BIT_FIRST;
            modeQ   <= cfg_prom_pkg::MODE_RESET;
            ccPrevQ <= 1'h0;
        end
        else
        begin
            stateQ  <= stateD;
            addrQ   <= addrD;
            bitQ    <= bitD;
            modeQ   <= modeD;
            ccPrevQ <= ccPrevD;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            serialDataOut     <= 1'h0;
            serialDataOe      <= 1'h0;
            parallelDataOut   <= 7'h00;
            parallelDataOe    <= 1'h0;
            cascadeEnableOutN <= 1'h1;
        end
        else
        begin
            serialDataOut     <= serialD;
            serialDataOe      <= serialOeD;
            parallelDataOut   <= upperD;
            parallelDataOe    <= upperOeD;
            cascadeEnableOutN <= cascadeD;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            oeResetOutN <= 1'h0;
            oeResetOe   <= 1'h1;
        end
        else
        begin
            oeResetOutN <= lineLowD;
            oeResetOe   <= lineOeD;
        end
    end
endmodule

// ### core/cfg_prom_pkg.sv
// Constants and types shared by the configuration memory read-out logic
package cfg_prom_pkg;
    localparam int unsigned ADDR_W         = 10;
    localparam int unsigned MEM_DEPTH      = 1024;
    localparam logic [9:0]  TERMINAL_COUNT = 10'h3FF;
    localparam logic [9:0]  ADDR_RESET     = 10'h000;
    localparam logic [2:0]  BIT_FIRST      = 3'h0;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic        MODE_RESET     = 1'b0;
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned POWERUP_HOLD_NS = 1000000;
    localparam int unsigned HOLD_CYCLES    = (POWERUP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_W         = 20;

    typedef enum logic [1:0] {
        ST_HELD = 2'b00,
        ST_SEND = 2'b01,
        ST_DONE = 2'b10
    } readout_state_type;
endpackage

// ### core/rst_hold_if.sv
// Carrier between the read-out core and its power-up hold timer
`timescale 1ns/1ns
interface rst_hold_if;
    logic brownOut;
    logic holdActive;

    modport hold
    (
        input  brownOut,
        output holdActive
    );
    modport user
    (
        output brownOut,
        input  holdActive
    );
endinterface

// ### core/reset_hold.sv
// Power-up and brown-out hold timer for the output-enable/reset line
`timescale 1ns/1ns
module reset_hold #(
    parameter int unsigned HOLD_CYCLES = cfg_prom_pkg::HOLD_CYCLES
)(
    input wire logic clk,
    input wire logic sys_rst,
    rst_hold_if.hold hif
);
    logic [cfg_prom_pkg::HOLD_W-1:0] cntQ;
    logic [cfg_prom_pkg::HOLD_W-1:0] cntD;
    logic                            holdQ;
    logic                            holdD;

    always_comb
    begin
        cntD = cntQ;
        if (hif.brownOut)
        begin
            cntD = cfg_prom_pkg::HOLD_W'(HOLD_CYCLES);
        end
        else if (cntQ != '0)
        begin
            cntD = cntQ - 1'b1;
        end
        holdD = (cntD != '0);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cntQ  <= cfg_prom_pkg::HOLD_W'(HOLD_CYCLES);
            holdQ <= 1'b1;
        end
        else
        begin
            cntQ  <= cntD;
            holdQ <= holdD;
        end
    end

    assign hif.holdActive = holdQ;
endmodule

// ### dv/config_prom_props.sv
// Port checker for the configuration memory read-out core
`timescale 1ns/1ns
module config_prom_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic configClock,
    input wire logic chipEnableN,
    input wire logic oeResetInN,
    input wire logic supplyLow,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic parallelDataOe,
    input wire logic cascadeEnableOutN,
    input wire logic oeResetOe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_rise;
        $past(configClock) && !$past(configClock, 2);
    endsequence
    sequence s_enabled;
        $rose(oeResetInN) && !chipEnableN && !supplyLow ##1 (oeResetInN && !chipEnableN)[*2];
    endsequence
    a_held_floats: assert property (!oeResetInN |=> !serialDataOe && !parallelDataOe
        && cascadeEnableOutN) else $error("outputs active while reset line low");
    a_standby_floats: assert property (chipEnableN |=> !serialDataOe && !parallelDataOe
        && cascadeEnableOutN) else $error("outputs active in standby");
    a_hold_after_reset: assert property ($fell(sys_rst) |-> oeResetOe[*8])
        else $error("reset line released too early");
    a_brownout_holds: assert property (supplyLow |-> ##2 (oeResetOe && !serialDataOe))
        else $error("brown-out did not hold reset line");
    a_cascade_floats: assert property (!cascadeEnableOutN |-> !serialDataOe && !parallelDataOe)
        else $error("data driven past terminal count");
    a_cascade_after_rise: assert property ($fell(cascadeEnableOutN) |-> s_rise)
        else $error("cascade enable fell without a clock rise");
    a_data_after_rise: assert property (serialDataOe && $past(serialDataOe)
        && $changed(serialDataOut) |-> s_rise) else $error("data changed without a rise");
    a_first_data: assert property (s_enabled |-> serialDataOe)
        else $error("data not driven after enable");
    a_byte_lanes: assert property (parallelDataOe |-> serialDataOe)
        else $error("byte lanes driven without bit 0");
endmodule
bind config_prom_readout config_prom_props config_prom_props_i (.clk(clk), .sys_rst(sys_rst),
    .configClock(configClock), .chipEnableN(chipEnableN), .oeResetInN(oeResetInN),
    .supplyLow(supplyLow), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .parallelDataOe(parallelDataOe), .cascadeEnableOutN(cascadeEnableOutN),
    .oeResetOe(oeResetOe));

// ### dv/fpga_port.sv
// Model of the configuring master: clock, chip enable and shared reset wire
`timescale 1ns/1ns
module fpga_port (
    input  wire logic clk,
    input  wire logic oeResetOutN,
    input  wire logic oeResetOe,
    output logic      configClock,
    output logic      chipEnableN,
    output logic      oeResetInN
);
    logic pullLow;
    int   half;
    // Pulled-up wire, low if either party pulls; mode selects assumed all low
    assign oeResetInN = !(oeResetOe && !oeResetOutN) && !pullLow;
    initial
    begin
        configClock = 1'b0;
        chipEnableN = 1'b1;
        pullLow = 1'b1;
        half = 1;
    end
    // Clock stands low between pulses; half sets prompt or slow rate
    task automatic pulse();
        configClock = 1'b1;
        repeat (half) @(negedge clk);
        configClock = 1'b0;
        repeat (half) @(negedge clk);
    endtask
endmodule

// ### dv/config_prom_readout_tb.sv
// Testbench for the configuration memory read-out core
`timescale 1ns/1ns
module config_prom_readout_tb;
    localparam int HOLD = 20;
    logic       clk, sys_rst, configClock, chipEnableN, oeResetInN, parallelMode, supplyLow;
    logic       progWe, serialDataOut, serialDataOe, parallelDataOe, cascadeEnableOutN;
    logic       oeResetOutN, oeResetOe;
    logic [9:0] progAddr;
    logic [7:0] progData;
    logic [6:0] parallelDataOut;
    int         errorCnt, totalChecks;
    config_prom_readout #(.HOLD_CYCLES(HOLD)) config_prom_readout_i (.clk(clk),
        .sys_rst(sys_rst), .configClock(configClock), .chipEnableN(chipEnableN),
        .oeResetInN(oeResetInN), .parallelMode(parallelMode), .supplyLow(supplyLow),
        .progWe(progWe), .progAddr(progAddr), .progData(progData),
        .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
        .parallelDataOut(parallelDataOut), .parallelDataOe(parallelDataOe),
        .cascadeEnableOutN(cascadeEnableOutN), .oeResetOutN(oeResetOutN), .oeResetOe(oeResetOe));
    fpga_port fpga_port_i (.clk(clk), .oeResetOutN(oeResetOutN), .oeResetOe(oeResetOe),
        .configClock(configClock), .chipEnableN(chipEnableN), .oeResetInN(oeResetInN));
    always #2 clk = ~clk;
    function automatic logic [7:0] pat(input int a);
        return 8'(a * 37 + 11);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic read_out(input int a0, input int n, input logic par);
        logic [7:0] got;
        repeat (4) @(negedge clk);
        for (int a = a0; a < a0 + n; a++)
        begin
            got = {parallelDataOut, serialDataOut};
            for (int b = 7; b >= 0 && !par; b--)
            begin
                got[b] = serialDataOut;
                fpga_port_i.pulse();
            end
            if (par)
                fpga_port_i.pulse();
            check(got, pat(a));
        end
    endtask
    task automatic t_end();
        fpga_port_i.pulse();
        check(8'({serialDataOe, parallelDataOe, cascadeEnableOutN}), 8'h00);
        $display("test end of data done");
    endtask
    task automatic t_hold();
        repeat (HOLD - 2) @(negedge clk);
        check(8'({oeResetOe, oeResetInN}), 8'h02);
        repeat (5) @(negedge clk);
        check(8'({oeResetOe, oeResetInN}), 8'({1'h0, !fpga_port_i.pullLow}));
        $display("test reset hold done");
    endtask
    task automatic t_abort();
        fpga_port_i.half = 3;
        fpga_port_i.pullLow = 1;
        repeat (2) @(negedge clk);
        check(8'({serialDataOe, cascadeEnableOutN}), 8'h01);
        fpga_port_i.pullLow = 0;
        read_out(0, 3, 1'b0);
        fpga_port_i.chipEnableN = 1;
        fpga_port_i.pulse();
        check(8'({serialDataOe, cascadeEnableOutN}), 8'h01);
        fpga_port_i.chipEnableN = 0;
        read_out(0, 2, 1'b0);
        $display("test abort done");
    endtask
    task automatic t_serial();
        for (int a = 0; a < 1024; a++)
        begin
            {progWe, progAddr, progData} = {1'h1, 10'(a), pat(a)};
            @(negedge clk);
        end
        progWe = 1'h0;
        fpga_port_i.chipEnableN = 1'h0;
        fpga_port_i.pullLow = 1'h0;
        read_out(0, 1024, 1'h0);
        $display("test serial read-out done");
    endtask
    task automatic t_parallel();
        fpga_port_i.pullLow = 1'h1;
        parallelMode = 1'h1;
        repeat (2) @(negedge clk);
        fpga_port_i.pullLow = 1'h0;
        read_out(0, 4, 1'h1);
        parallelMode = 1'h0;
        read_out(4, 1020, 1'h1);
        $display("test parallel read-out done");
    endtask
    task automatic t_brownout();
        supplyLow = 1'h1;
        @(negedge clk);
        supplyLow = 1'h0;
        t_hold();
        read_out(0, 1, 1'h0);
        $display("test brown-out done");
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        errorCnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        finishTest();
    end
    initial
    begin
        clk = 1'h0;
        sys_rst = 1'h1;
        parallelMode = 1'h0;
        supplyLow = 1'h0;
        progWe = 1'h0;
        progAddr = 10'h000;
        progData = 8'h00;
        errorCnt = 0;
        totalChecks = 0;
        repeat (12) @(negedge clk);
        sys_rst = 1'h0;
        t_hold();
        t_serial();
        t_end();
        t_abort();
        t_parallel();
        t_end();
        t_brownout();
        finishTest();
    end
endmodule
